// file: rtl/dcc_top.sv
// dual comparator control: registers, edge flags, output gating
`timescale 1ns/1ns

// per-comparator control and edge logic
module dcc_channel (
	input  wire logic                  ref_clk_i,
	input  wire logic                  rst_n_i,
	input  wire logic                  cmp_raw_i,
	input  wire logic                  wr_i,
	input  wire logic [7:0]            wdata_i,
	output logic                       cmp_sync_o,
	output dcc_pkg::dcc_cmp_out_t      st_o
);
	import dcc_pkg::*;
	dcc_state_t s_q, s_d;
	logic       rise_ev;
	logic       fall_ev;

	// edges only count while enabled
	assign rise_ev = s_q.en & s_q.sync2 & ~s_q.prev;
	assign fall_ev = s_q.en & ~s_q.sync2 & s_q.prev;

	always_comb begin
		s_d       = s_q;
		s_d.sync1 = cmp_raw_i;
		s_d.sync2 = s_q.sync1;
		s_d.prev  = s_q.sync2;
		if (wr_i) begin
			s_d.en   = wdata_i[DCC_EN_BIT];
			s_d.hyp  = wdata_i[DCC_HYP_LSB +: 2];
			s_d.hyn  = wdata_i[DCC_HYN_LSB +: 2];
			if (!wdata_i[DCC_RISE_BIT]) s_d.rise = 1'b0;
			if (!wdata_i[DCC_FALL_BIT]) s_d.fall = 1'b0;
		end
		if (rise_ev) s_d.rise = 1'b1;
		if (fall_ev) s_d.fall = 1'b1;
		if (wr_i && wdata_i[DCC_EN_BIT] && !s_q.en)
			s_d.settle_cnt = DCC_CNT_W'(DCC_SETTLE_CYC);
		else if (s_q.settle_cnt != '0)
			s_d.settle_cnt = s_q.settle_cnt - 1'b1;
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			s_q            <= '0;
			s_q.settle_cnt <= DCC_CNT_W'(DCC_SETTLE_CYC);
		end else begin
			s_q <= s_d;
		end
	end

	assign cmp_sync_o   = s_q.sync2;
	assign st_o.en        = s_q.en;
	assign st_o.rise_flag = s_q.rise;
	assign st_o.fall_flag = s_q.fall;
	assign st_o.hyst_pos  = s_q.hyp;
	assign st_o.hyst_neg  = s_q.hyn;
	assign st_o.settled   = (s_q.settle_cnt == '0);

	a_rise_sets_flag: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		rise_ev |=> s_q.rise) else $error("rise edge did not set flag");
	a_fall_sets_flag: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		fall_ev |=> s_q.fall) else $error("fall edge did not set flag");
	a_flag_sticky: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		s_q.rise && !wr_i |=> s_q.rise) else $error("rise flag dropped");
	a_write_clears: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		wr_i && !wdata_i[DCC_FALL_BIT] && !fall_ev |=> !s_q.fall)
		else $error("fall flag not cleared");
	a_disabled_quiet: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		!s_q.en && !s_q.rise && !wr_i |=> !s_q.rise)
		else $error("flag set while disabled");
	a_enable_follows: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		wr_i |=> s_q.en == $past(wdata_i[DCC_EN_BIT]))
		else $error("enable not taken");
	a_settle_start: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		wr_i && wdata_i[DCC_EN_BIT] && !s_q.en |=> !st_o.settled [*8])
		else $error("settle window too short");
	a_sync_two: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		s_q.sync2 == $past(cmp_raw_i, 2) || $past(!rst_n_i, 2))
		else $error("sync depth wrong");
	c_rise: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) rise_ev);
	c_fall: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) fall_ev);
	c_clash: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		wr_i && !wdata_i[DCC_RISE_BIT] && rise_ev);
	c_settled: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		s_q.en && st_o.settled);
endmodule : dcc_channel

// Functional notes
// - each comparator enabled by bit 7 of its control register, independently
// - disabled comparator forces pin output low and suspends edge flags
// - interrupts raised on both rising and falling output transitions
// - falling transition of comparator zero sets flag at bit 4
// - rising transition of comparator zero sets flag at bit 5
// - edge flags stay set until CPU clears them
// - bit 6 reads current comparator output state, read only
// - output unsettled for 20 us after enable or power-up
// - bits 1-0 select negative hysteresis, 00 off, 11 largest
// - bits 3-2 select positive hysteresis with same code scheme
// - comparator zero output offered as a reset source
// - comparator one offers no reset source, otherwise identical
// - comparator one replicates all functions except the reset source in its own register
module dcc_top (
	input  wire logic                  ref_clk_i,
	input  wire logic                  rst_n_i,
	input  wire logic [7:0]            sfr_addr_i,
	input  wire logic                  sfr_wr_i,
	input  wire logic [7:0]            sfr_wdata_i,
	output logic      [7:0]            sfr_rdata_o,
	input  wire logic                  cmp0_raw_i,
	input  wire logic                  cmp1_raw_i,
	output dcc_pkg::dcc_cmp_out_t      cmp0_ctrl_o,
	output dcc_pkg::dcc_cmp_out_t      cmp1_ctrl_o,
	output logic                       cmp0_pin_o,
	output logic                       cmp1_pin_o,
	output logic                       cmp0_irq_o,
	output logic                       cmp1_irq_o,
	output logic                       cmp0_reset_src_o
);
	import dcc_pkg::*;
	logic sync0, sync1;
	logic wr0, wr1;

	always_comb begin
		wr0 = 1'b0;
		wr1 = 1'b0;
		if (sfr_addr_i == DCC_ZERO_CTRL_ADDR) wr0 = sfr_wr_i;
		else if (sfr_addr_i == DCC_ONE_CTRL_ADDR) wr1 = sfr_wr_i;
	end

	dcc_channel u_cmp0 (
		.ref_clk_i  (ref_clk_i),
		.rst_n_i    (rst_n_i),
		.cmp_raw_i  (cmp0_raw_i),
		.wr_i       (wr0),
		.wdata_i    (sfr_wdata_i),
		.cmp_sync_o (sync0),
		.st_o       (cmp0_ctrl_o)
	);
	dcc_channel u_cmp1 (
		.ref_clk_i  (ref_clk_i),
		.rst_n_i    (rst_n_i),
		.cmp_raw_i  (cmp1_raw_i),
		.wr_i       (wr1),
		.wdata_i    (sfr_wdata_i),
		.cmp_sync_o (sync1),
		.st_o       (cmp1_ctrl_o)
	);

	always_comb begin
		sfr_rdata_o = 8'h00;
		if (sfr_addr_i == DCC_ZERO_CTRL_ADDR)
			sfr_rdata_o = {cmp0_ctrl_o.en, sync0, cmp0_ctrl_o.rise_flag,
				cmp0_ctrl_o.fall_flag, cmp0_ctrl_o.hyst_pos, cmp0_ctrl_o.hyst_neg};
		else if (sfr_addr_i == DCC_ONE_CTRL_ADDR)
			sfr_rdata_o = {cmp1_ctrl_o.en, sync1, cmp1_ctrl_o.rise_flag,
				cmp1_ctrl_o.fall_flag, cmp1_ctrl_o.hyst_pos, cmp1_ctrl_o.hyst_neg};
	end

	assign cmp0_pin_o       = cmp0_ctrl_o.en & sync0;
	assign cmp1_pin_o       = cmp1_ctrl_o.en & sync1;
	assign cmp0_irq_o       = cmp0_ctrl_o.rise_flag | cmp0_ctrl_o.fall_flag;
	assign cmp1_irq_o       = cmp1_ctrl_o.rise_flag | cmp1_ctrl_o.fall_flag;
	assign cmp0_reset_src_o = cmp0_pin_o;

	a_pin0_gated: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		!cmp0_ctrl_o.en |-> !cmp0_pin_o)
		else $error("pin 0 high while disabled");

	a_pin1_gated: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		!cmp1_ctrl_o.en |-> !cmp1_pin_o)
		else $error("pin 1 high while disabled");

	a_rsrc_follows: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		cmp0_reset_src_o == cmp0_pin_o)
		else $error("reset source differs from output");

	a_zero_isolated: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		sfr_wr_i && sfr_addr_i != DCC_ZERO_CTRL_ADDR |=> $stable(cmp0_ctrl_o.en)
		&& $stable(cmp0_ctrl_o.hyst_pos) && $stable(cmp0_ctrl_o.hyst_neg))
		else $error("comparator zero changed by foreign write");

	a_one_isolated: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		sfr_wr_i && sfr_addr_i != DCC_ONE_CTRL_ADDR |=> $stable(cmp1_ctrl_o.en)
		&& $stable(cmp1_ctrl_o.hyst_pos) && $stable(cmp1_ctrl_o.hyst_neg))
		else $error("comparator one changed by foreign write");

	a_hyn_write: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		sfr_wr_i && sfr_addr_i == DCC_ZERO_CTRL_ADDR
		|=> cmp0_ctrl_o.hyst_neg == $past(sfr_wdata_i[DCC_HYN_LSB +: 2]))
		else $error("negative hysteresis not taken");

	a_hyp_write: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		sfr_wr_i && sfr_addr_i == DCC_ZERO_CTRL_ADDR
		|=> cmp0_ctrl_o.hyst_pos == $past(sfr_wdata_i[DCC_HYP_LSB +: 2]))
		else $error("positive hysteresis not taken");

	a_hyp1_write: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		sfr_wr_i && sfr_addr_i == DCC_ONE_CTRL_ADDR
		|=> cmp1_ctrl_o.hyst_pos == $past(sfr_wdata_i[DCC_HYP_LSB +: 2]))
		else $error("comparator one hysteresis not taken");

	a_out_view: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		sfr_addr_i == DCC_ZERO_CTRL_ADDR && cmp0_ctrl_o.en
		|-> sfr_rdata_o[DCC_OUT_BIT] == cmp0_pin_o)
		else $error("output bit differs from output");

	a_unmapped_zero: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		sfr_addr_i != DCC_ZERO_CTRL_ADDR && sfr_addr_i != DCC_ONE_CTRL_ADDR
		|-> sfr_rdata_o == 8'h00)
		else $error("unmapped address reads nonzero");

	a_irq0_quiet: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		!cmp0_ctrl_o.en && !cmp0_irq_o && !sfr_wr_i |=> !cmp0_irq_o)
		else $error("irq 0 raised while disabled");

	a_irq1_quiet: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i)
		!cmp1_ctrl_o.en && !cmp1_irq_o && !sfr_wr_i |=> !cmp1_irq_o)
		else $error("irq 1 raised while disabled");

	c_pin0: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) cmp0_pin_o);
endmodule : dcc_top

// file: rtl/dcc_pkg.sv
// package for the dual comparator control block
package dcc_pkg;
	localparam logic [7:0] DCC_ZERO_CTRL_ADDR = 8'h9e;
	localparam logic [7:0] DCC_ONE_CTRL_ADDR  = 8'h9f;
	localparam logic [7:0] DCC_CTRL_RESET     = 8'h00;
	localparam int         DCC_EN_BIT         = 7;
	localparam int         DCC_OUT_BIT        = 6;
	localparam int         DCC_RISE_BIT       = 5;
	localparam int         DCC_FALL_BIT       = 4;
	localparam int         DCC_HYP_LSB        = 2;
	localparam int         DCC_HYN_LSB        = 0;
	localparam int         DCC_SETTLE_US      = 20;
	localparam int         DCC_CLK_MHZ        = 125;
	localparam int         DCC_SETTLE_CYC     = DCC_SETTLE_US * DCC_CLK_MHZ;
	localparam int         DCC_CNT_W          = 12;

	typedef struct packed {
		logic       enable;
		logic       rise_flag;
		logic       fall_flag;
		logic [1:0] hyst_pos;
		logic [1:0] hyst_neg;
	} dcc_ctrl_t;

	typedef struct packed {
		logic       en;
		logic       rise_flag;
		logic       fall_flag;
		logic [1:0] hyst_pos;
		logic [1:0] hyst_neg;
		logic       settled;
	} dcc_cmp_out_t;

	typedef struct packed {
		logic                 sync1;
		logic                 sync2;
		logic                 prev;
		logic                 en;
		logic                 rise;
		logic                 fall;
		logic [1:0]           hyp;
		logic [1:0]           hyn;
		logic [DCC_CNT_W-1:0] settle_cnt;
	} dcc_state_t;
endpackage : dcc_pkg

// file: tb/dcc_cmp_model.sv
// analog comparator core model for the bench
`timescale 1ns/1ns
module dcc_cmp_model (
	input  wire logic ref_clk_i,
	input  wire logic en_i,
	input  wire logic noisy_i,
	input  wire logic level_i,
	output logic      raw_o
);
	logic junk_q = 1'b0;
	always @(posedge ref_clk_i) begin
		junk_q <= ~junk_q;
	end
	// a core in shutdown may chatter, so its output means nothing then
	assign raw_o = en_i ? level_i : (noisy_i & junk_q);
endmodule // dcc_cmp_model

// file: tb/tb.sv
// self-checking bench for the dual comparator control
`timescale 1ns/1ns
module tb;
	import dcc_pkg::*;
	logic         ref_clk_i = 1'b0, rst_n_i = 1'b0, sfr_wr_i = 1'b0;
	logic         lv0 = 1'b0, lv1 = 1'b0, nz = 1'b0;
	logic [7:0]   sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, rdata;
	logic         raw0, raw1, pin0, pin1, irq0, irq1, rsrc;
	dcc_cmp_out_t c0, c1;
	int           num_errors = 0, checks_done = 0, cyc = 0;
	logic [7:0]   rows [8][3] = '{'{8'h9e, 8'h01, 8'h01}, '{8'h9e, 8'h02, 8'h02},
		'{8'h9e, 8'h03, 8'h03}, '{8'h9e, 8'h0c, 8'h0c}, '{8'h9e, 8'hb4, 8'h84},
		'{8'h9f, 8'h89, 8'h89}, '{8'ha0, 8'hff, 8'h00}, '{8'h9e, 8'h00, 8'h00}};
	always #4 ref_clk_i = ~ref_clk_i;
	dcc_cmp_model u_m0 (.ref_clk_i(ref_clk_i), .en_i(c0.en), .noisy_i(nz), .level_i(lv0),
		.raw_o(raw0));
	dcc_cmp_model u_m1 (.ref_clk_i(ref_clk_i), .en_i(c1.en), .noisy_i(nz), .level_i(lv1),
		.raw_o(raw1));
	dcc_top u_dcc_top (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .sfr_addr_i(sfr_addr_i),
		.sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(rdata),
		.cmp0_raw_i(raw0), .cmp1_raw_i(raw1), .cmp0_ctrl_o(c0), .cmp1_ctrl_o(c1),
		.cmp0_pin_o(pin0), .cmp1_pin_o(pin1), .cmp0_irq_o(irq0), .cmp1_irq_o(irq1),
		.cmp0_reset_src_o(rsrc));
	task automatic stop_test();
		if (num_errors == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic chk8(string n, logic [7:0] e, logic [7:0] s);
		checks_done++;
		if (s !== e) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic chk1(string n, logic e, logic s);
		chk8(n, {7'h00, e}, {7'h00, s});
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge ref_clk_i);
		sfr_addr_i  <= a;
		sfr_wdata_i <= d;
		sfr_wr_i    <= 1'b1;
		@(posedge ref_clk_i);
		sfr_wr_i    <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] e);
		@(posedge ref_clk_i);
		sfr_addr_i <= a;
		@(negedge ref_clk_i);
		chk8("rdata", e, rdata);
	endtask
	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 4000) begin
			num_errors++;
			stop_test();
		end
	end
	initial begin
		repeat (3) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		rd(8'h9e, 8'h00);
		rd(8'h9f, 8'h00);
		chk1("irq0", 1'b0, irq0);
		foreach (rows[i]) begin
			wr(rows[i][0], rows[i][1]);
			rd(rows[i][0], rows[i][2]);
		end
		wr(8'h9e, 8'h80);
		@(negedge ref_clk_i);
		chk1("settled", 1'b0, c0.settled);
		repeat (8) @(posedge ref_clk_i);
		wr(8'h9e, 8'h80);
		lv0 <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		rd(8'h9e, 8'he0);
		chk1("irq0", 1'b1, irq0);
		chk1("pin0", 1'b1, pin0);
		chk1("rsrc", 1'b1, rsrc);
		@(posedge ref_clk_i);
		lv0 <= 1'b0;
		repeat (4) @(posedge ref_clk_i);
		rd(8'h9e, 8'hb0);
		wr(8'h9e, 8'h80);
		rd(8'h9e, 8'h80);
		@(posedge ref_clk_i);
		lv0 <= 1'b1;
		@(posedge ref_clk_i);
		wr(8'h9e, 8'h80);
		rd(8'h9e, 8'he0);
		@(posedge ref_clk_i);
		nz <= 1'b1;
		lv1 <= 1'b1;
		wr(8'h9f, 8'h00);
		repeat (20) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
		chk1("pin1", 1'b0, pin1);
		chk1("irq1", 1'b0, irq1);
		repeat (2500) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
		chk1("settled", 1'b1, c0.settled);
		wr(8'h9e, 8'h00);
		@(negedge ref_clk_i);
		chk1("pin0", 1'b0, pin0);
		stop_test();
	end
endmodule // tb
